// *** hw/ddp_pkg.sv ***
// Shared constants, command codes and states for the DDR pin interface
package ddp_pkg;

   // Bus widths
   localparam int unsigned DATA_W = 64; // Data lines
   localparam int unsigned ECC_W = 8; // Check-bit lines
   localparam int unsigned LANES = 9; // Eight data bytes plus the check byte
   localparam int unsigned BEAT_W = DATA_W + ECC_W; // One beat on the pins
   localparam int unsigned ROWS = 4; // Memory rows
   localparam int unsigned ROW_W = 2; // Row number width
   localparam int unsigned ADDR_W = 13; // Multiplexed address width
   localparam int unsigned BANK_W = 2; // Bank select width
   localparam int unsigned SYNC_W = 2 + LANES + BEAT_W; // Pin inputs sampled

   // Burst, latency and buffer depth defaults
   localparam int unsigned BURST_BEATS = 2; // Beats per burst, one per strobe edge
   localparam int unsigned CAS_LATENCY = 2; // Read latency in memory clocks
   localparam int unsigned FIFO_DEPTH = 8; // Write data buffer depth
   localparam int unsigned CNT_W = 5; // Edge counter width

   // Reset and self refresh values of the pins
   localparam logic [ROWS-1:0] CS_NONE = 4'hf; // No row selected
   localparam logic [ROWS-1:0] CS_ALL = 4'h0; // Every row selected
   localparam logic [ROWS-1:0] CKE_AWAKE = 4'hf; // Clocks running
   localparam logic [ROWS-1:0] CKE_SLEEP = 4'h0; // Self refresh held
   localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000; // Address at reset
   localparam logic [BANK_W-1:0] BANK_RST = 2'h0; // Bank at reset
   localparam logic [SYNC_W-1:0] SYNC_RST = {1'b1, 82'h0}; // Gate idle high

   // Command codes as {row strobe, column strobe, write enable}, all active low
   typedef enum logic [2:0] {
      CMD_MRS = 3'h0,
      CMD_REFRESH = 3'h1,
      CMD_PRECHARGE = 3'h2,
      CMD_ACTIVE = 3'h3,
      CMD_WRITE = 3'h4,
      CMD_READ = 3'h5,
      CMD_BURST_STOP = 3'h6,
      CMD_NOP = 3'h7
   } ddp_cmd_e;

   // Sequencer states, Gray coded along idle, write, read, suspend
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_WRITE = 2'h1,
      ST_READ = 2'h3,
      ST_SUSP = 2'h2
   } ddp_state_e;

endpackage : ddp_pkg

// *** hw/ddp_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ddp_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta; // First stage, read only by the second

   // Both stages reset to constants
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end

endmodule : ddp_sync
`default_nettype wire

// *** hw/ddp_fifo.sv ***
// Write data FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ddp_fifo #(
   parameter int unsigned W = 72,
   parameter int unsigned DEPTH = 8,
   localparam int unsigned AW = $clog2(DEPTH),
   localparam int unsigned CW = $clog2(DEPTH + 1)
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o,
   output logic [CW-1:0] count_o
);

   logic [W-1:0] mem [DEPTH]; // Storage
   logic [AW-1:0] wr_ptr, next_wr_ptr; // Fill pointer
   logic [AW-1:0] rd_ptr, next_rd_ptr; // Drain pointer
   logic [CW-1:0] next_count; // Occupancy
   logic push, pop; // Handshakes

   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem[rd_ptr];

   // Pointers and count; ready and valid are registered from the next count
   always_comb begin
      next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr; // Depth is a power of two
      next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      next_count = CW'(count_o + CW'(push) - CW'(pop));
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count_o <= '0;
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count_o <= next_count;
         in_ready_o <= (next_count != CW'(DEPTH)); // Honest full
         out_valid_o <= (next_count != '0); // Honest empty
      end
   end

   // Storage needs no reset
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

endmodule : ddp_fifo
`default_nettype wire

// *** hw/ddp_pin_interface.sv ***
// DDR SDRAM pin interface: command, address, data, strobe and receive gate logic
//
// Summary of operation
// - One active-low chip select per row
// - Chip selects may change every memory rising edge
// - Thirteen-bit address carries row then column
// - Two-bit bank select picks bank within row
// - Row, column, write strobes encode each command
// - Sixty-four data lines, driven on writes only
// - Eight check-bit lines travel with the data
// - Nine strobes: one per data byte, one check
// - Four clock enables, changeable every rising edge
// - Drive receive gate out, looped back externally
// - Returned gate admits strobes only during reads
`timescale 1ns/1ps
`default_nettype none
module ddp_pin_interface #(
   parameter int unsigned BURST = ddp_pkg::BURST_BEATS,
   parameter int unsigned CAS_LAT = ddp_pkg::CAS_LATENCY,
   parameter int unsigned FIFO_DEPTH = ddp_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cmd_valid_i,
   input wire logic [2:0] cmd_op_i,
   input wire logic [ddp_pkg::ROW_W-1:0] cmd_row_i,
   input wire logic [ddp_pkg::ADDR_W-1:0] cmd_addr_i,
   input wire logic [ddp_pkg::BANK_W-1:0] cmd_bank_i,
   output logic cmd_ack_o,
   input wire logic suspend_i,
   output logic suspended_o,
   input wire logic wr_data_valid_i,
   output logic wr_data_ready_o,
   input wire logic [ddp_pkg::BEAT_W-1:0] wr_data_i,
   output logic rd_data_valid_o,
   output logic [ddp_pkg::DATA_W-1:0] rd_data_o,
   output logic [ddp_pkg::ECC_W-1:0] rd_ecc_o,
   input wire logic mem_clock_i,
   output logic [ddp_pkg::ROWS-1:0] row_chip_select_n_o,
   output logic [ddp_pkg::ADDR_W-1:0] mux_mem_addr_o,
   output logic [ddp_pkg::BANK_W-1:0] bank_select_o,
   output logic row_strobe_n_o,
   output logic col_strobe_n_o,
   output logic mem_write_en_n_o,
   output logic [ddp_pkg::ROWS-1:0] row_clock_enable_o,
   input wire logic [ddp_pkg::DATA_W-1:0] mem_data_i,
   output logic [ddp_pkg::DATA_W-1:0] mem_data_o,
   output logic mem_data_oe_n_o,
   input wire logic [ddp_pkg::ECC_W-1:0] ecc_check_bits_i,
   output logic [ddp_pkg::ECC_W-1:0] ecc_check_bits_o,
   output logic ecc_check_bits_oe_n_o,
   input wire logic [ddp_pkg::LANES-1:0] byte_data_strobe_i,
   output logic [ddp_pkg::LANES-1:0] byte_data_strobe_o,
   output logic byte_data_strobe_oe_n_o,
   output logic rx_gate_feedback_out_n_o,
   input wire logic rx_gate_feedback_in_n_i
);

   localparam int unsigned CW = $clog2(FIFO_DEPTH + 1); // FIFO count width
   localparam int unsigned LW = ddp_pkg::LANES; // Strobe lanes
   localparam logic [ddp_pkg::CNT_W-1:0] WR_FIRST = 5'h02; // Edge of first write beat
   localparam logic [ddp_pkg::CNT_W-1:0] WR_END = ddp_pkg::CNT_W'(BURST + 2);
   localparam logic [ddp_pkg::CNT_W-1:0] GATE_RISES = ddp_pkg::CNT_W'(CAS_LAT + BURST / 2 + 1);

   // Synchronised pin inputs
   logic [ddp_pkg::SYNC_W-1:0] sync_q; // All sampled pins
   logic gate_n_s; // Returned receive gate
   logic mclk_s; // Memory clock level
   logic [LW-1:0] dqs_s; // Strobe levels
   logic [ddp_pkg::BEAT_W-1:0] beat_s; // Check bits over data
   logic mclk_d; // Previous clock level, for edges
   logic [LW-1:0] dqs_d; // Previous strobe levels
   logic rise_evt, fall_evt, edge_evt; // Memory clock edges

   // Write FIFO drain side
   logic fifo_valid; // A beat is waiting
   logic fifo_pop; // Take a beat
   logic [ddp_pkg::BEAT_W-1:0] fifo_data; // Head beat
   logic [CW-1:0] fifo_count; // Occupancy

   // Sequencer state
   ddp_pkg::ddp_state_e state, next_state; // Current activity
   logic [ddp_pkg::CNT_W-1:0] cnt, next_cnt; // Edges or rises since command
   logic [ddp_pkg::CNT_W-1:0] cnt_now; // Count including this edge
   logic accept; // Command taken this cycle
   logic [ddp_pkg::ROWS-1:0] next_cs, next_cke;
   logic [ddp_pkg::ADDR_W-1:0] next_addr;
   logic [ddp_pkg::BANK_W-1:0] next_bank;
   logic [2:0] cmd_q, next_cmd; // Row, column and write strobes
   logic next_ack, next_gate_n;
   logic [ddp_pkg::BEAT_W-1:0] next_wbeat; // Beat on the pins
   logic next_oe_n, next_dqs_oe_n;
   logic next_dqs; // Common write strobe level

   // Read capture
   logic [LW-1:0] got; // Lane has its byte for this beat
   logic [LW-1:0] cap; // Lane captures this cycle
   logic [ddp_pkg::BEAT_W-1:0] lane_bus; // Captured bytes
   logic beat_done; // Every lane captured
   logic [ddp_pkg::BEAT_W-1:0] rd_beat_q;

   // All pins enter through one two-stage sampler
   ddp_sync #(.W(ddp_pkg::SYNC_W), .RST_VAL(ddp_pkg::SYNC_RST)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({rx_gate_feedback_in_n_i, mem_clock_i, byte_data_strobe_i, ecc_check_bits_i,
            mem_data_i}),
      .q_o(sync_q)
   );
   assign {gate_n_s, mclk_s, dqs_s, beat_s} = sync_q;

   // Write data buffer; its ready stalls the user when full
   ddp_fifo #(.W(ddp_pkg::BEAT_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(wr_data_valid_i),
      .in_ready_o(wr_data_ready_o),
      .in_data_i(wr_data_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_data),
      .count_o(fifo_count)
   );

   // Edge finding on the sampled levels
   assign rise_evt = mclk_s & ~mclk_d;
   assign fall_evt = ~mclk_s & mclk_d;
   assign edge_evt = rise_evt | fall_evt;
   assign cnt_now = ddp_pkg::CNT_W'(cnt + 1'b1);

   // A write waits until its whole burst is buffered, so the pins never underrun
   assign accept = rise_evt && (state == ddp_pkg::ST_IDLE) && !suspend_i && cmd_valid_i &&
                   (cmd_op_i != ddp_pkg::CMD_WRITE || fifo_count >= CW'(BURST));

   // Pop on every driven write beat
   assign fifo_pop = (state == ddp_pkg::ST_WRITE) && edge_evt && cnt_now >= WR_FIRST &&
                     cnt_now < WR_END && fifo_valid;

   // Sequencer next values
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_cs = row_chip_select_n_o;
      next_cke = row_clock_enable_o;
      next_addr = mux_mem_addr_o;
      next_bank = bank_select_o;
      next_cmd = cmd_q;
      next_ack = 1'b0;
      next_gate_n = rx_gate_feedback_out_n_o;
      next_wbeat = {ecc_check_bits_o, mem_data_o};
      next_oe_n = mem_data_oe_n_o;
      next_dqs_oe_n = byte_data_strobe_oe_n_o;
      next_dqs = byte_data_strobe_o[0];
      // Every rising edge defaults to deselect, so one-cycle selects are possible
      if (rise_evt) begin
         next_cs = ddp_pkg::CS_NONE;
         next_cmd = ddp_pkg::CMD_NOP;
      end
      case (state)
         ddp_pkg::ST_IDLE: begin
            if (rise_evt && suspend_i) begin
               // Self refresh to every row with the clock enables dropped
               next_cs = ddp_pkg::CS_ALL;
               next_cmd = ddp_pkg::CMD_REFRESH;
               next_cke = ddp_pkg::CKE_SLEEP;
               next_state = ddp_pkg::ST_SUSP;
            end else if (accept) begin
               next_ack = 1'b1;
               next_cs = ~(ddp_pkg::ROWS'(1) << cmd_row_i);
               next_cmd = cmd_op_i;
               next_addr = cmd_addr_i;
               next_bank = cmd_bank_i;
               next_cnt = '0;
               if (cmd_op_i == ddp_pkg::CMD_WRITE) begin
                  next_state = ddp_pkg::ST_WRITE;
               end else if (cmd_op_i == ddp_pkg::CMD_READ) begin
                  next_gate_n = 1'b0;
                  next_state = ddp_pkg::ST_READ;
               end
            end
         end
         ddp_pkg::ST_WRITE: begin
            if (edge_evt) begin
               next_cnt = cnt_now;
               if (cnt_now == 5'h01) begin
                  // Preamble: strobes driven low before the first beat
                  next_dqs_oe_n = 1'b0;
                  next_dqs = 1'b0;
               end else if (cnt_now < WR_END) begin
                  // One beat per edge, strobe toggling with each
                  next_oe_n = 1'b0;
                  next_wbeat = fifo_data;
                  next_dqs = ~cnt_now[0];
               end else begin
                  // Release every lane to the memory
                  next_oe_n = 1'b1;
                  next_dqs_oe_n = 1'b1;
                  next_dqs = 1'b0;
                  next_state = ddp_pkg::ST_IDLE;
               end
            end
         end
         ddp_pkg::ST_READ: begin
            // Gate window covers latency plus the burst, closed on a rise
            if (rise_evt) begin
               next_cnt = cnt_now;
               if (cnt_now == GATE_RISES) begin
                  next_gate_n = 1'b1;
                  next_state = ddp_pkg::ST_IDLE;
               end
            end
         end
         ddp_pkg::ST_SUSP: begin
            // Clock enables rise again once suspend is withdrawn
            if (rise_evt && !suspend_i) begin
               next_cke = ddp_pkg::CKE_AWAKE;
               next_state = ddp_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = ddp_pkg::ST_IDLE;
         end
      endcase
   end

   // Sequencer and pin registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ddp_pkg::ST_IDLE;
         cnt <= '0;
         mclk_d <= 1'b0;
         row_chip_select_n_o <= ddp_pkg::CS_NONE;
         row_clock_enable_o <= ddp_pkg::CKE_AWAKE;
         mux_mem_addr_o <= ddp_pkg::ADDR_RST;
         bank_select_o <= ddp_pkg::BANK_RST;
         cmd_q <= ddp_pkg::CMD_NOP;
         cmd_ack_o <= 1'b0;
         suspended_o <= 1'b0;
         rx_gate_feedback_out_n_o <= 1'b1;
         {ecc_check_bits_o, mem_data_o} <= '0;
         mem_data_oe_n_o <= 1'b1;
         ecc_check_bits_oe_n_o <= 1'b1;
         byte_data_strobe_oe_n_o <= 1'b1;
         byte_data_strobe_o <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         mclk_d <= mclk_s;
         row_chip_select_n_o <= next_cs;
         row_clock_enable_o <= next_cke;
         mux_mem_addr_o <= next_addr;
         bank_select_o <= next_bank;
         cmd_q <= next_cmd;
         cmd_ack_o <= next_ack;
         suspended_o <= (next_state == ddp_pkg::ST_SUSP);
         rx_gate_feedback_out_n_o <= next_gate_n;
         {ecc_check_bits_o, mem_data_o} <= next_wbeat;
         mem_data_oe_n_o <= next_oe_n;
         ecc_check_bits_oe_n_o <= next_oe_n; // Check bits move with the data
         byte_data_strobe_oe_n_o <= next_dqs_oe_n;
         byte_data_strobe_o <= {LW{next_dqs}};
      end
   end
   assign {row_strobe_n_o, col_strobe_n_o, mem_write_en_n_o} = cmd_q;

   // Per-lane capture: each strobe edge latches its own byte while the gate is open
   for (genvar l = 0; l < LW; l++) begin : g_lane
      logic [7:0] byte_q, next_byte; // Captured byte
      logic got_q, next_got; // Byte held for this beat
      assign cap[l] = (dqs_s[l] ^ dqs_d[l]) & ~gate_n_s;
      always_comb begin
         next_byte = byte_q;
         next_got = got_q;
         if (beat_done) begin
            next_got = 1'b0;
         end
         // A capture in the clearing cycle is kept
         if (cap[l]) begin
            next_byte = beat_s[8*l +: 8];
            next_got = 1'b1;
         end
      end
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            byte_q <= 8'h00;
            got_q <= 1'b0;
         end else begin
            byte_q <= next_byte;
            got_q <= next_got;
         end
      end
      assign got[l] = got_q;
      assign lane_bus[8*l +: 8] = byte_q;
   end
   assign beat_done = &got;

   // Read beat output and strobe history
   always_comb begin
      rd_beat_q = beat_done ? lane_bus : {rd_ecc_o, rd_data_o};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dqs_d <= '0;
         rd_data_valid_o <= 1'b0;
         {rd_ecc_o, rd_data_o} <= '0;
      end else begin
         dqs_d <= dqs_s;
         rd_data_valid_o <= beat_done;
         {rd_ecc_o, rd_data_o} <= rd_beat_q;
      end
   end

   // Checks
   chk_cs_one_row: assert property (@(posedge clk_i) disable iff (rst_i)
      $onehot0(~row_chip_select_n_o) || row_chip_select_n_o == ddp_pkg::CS_ALL)
      else $error("more than one row selected");
   chk_cs_on_rise: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(row_chip_select_n_o) |-> $past(rise_evt))
      else $error("chip select changed off a rising edge");
   chk_addr_taken: assert property (@(posedge clk_i) disable iff (rst_i)
      accept |=> mux_mem_addr_o == $past(cmd_addr_i) && cmd_ack_o)
      else $error("address not presented with command");
   chk_bank_taken: assert property (@(posedge clk_i) disable iff (rst_i)
      accept |=> bank_select_o == $past(cmd_bank_i))
      else $error("bank not presented with command");
   chk_cmd_code: assert property (@(posedge clk_i) disable iff (rst_i)
      accept |=> {row_strobe_n_o, col_strobe_n_o, mem_write_en_n_o} == $past(cmd_op_i)
      ##1 row_chip_select_n_o == $past(row_chip_select_n_o))
      else $error("command code wrong");
   chk_drive_write: assert property (@(posedge clk_i) disable iff (rst_i)
      !mem_data_oe_n_o |-> !ecc_check_bits_oe_n_o && !byte_data_strobe_oe_n_o &&
      rx_gate_feedback_out_n_o)
      else $error("data driven outside a write");
   chk_suspend_cke: assert property (@(posedge clk_i) disable iff (rst_i)
      suspended_o |-> row_clock_enable_o == ddp_pkg::CKE_SLEEP)
      else $error("clock enables high in suspend");
   chk_cke_on_rise: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(row_clock_enable_o) |-> $past(rise_evt))
      else $error("clock enable changed off a rising edge");
   chk_gate_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (accept && cmd_op_i == ddp_pkg::CMD_READ) |=> !rx_gate_feedback_out_n_o)
      else $error("receive gate not opened for read");
   chk_cap_gated: assert property (@(posedge clk_i) disable iff (rst_i)
      (|cap) |-> !gate_n_s && state != ddp_pkg::ST_WRITE)
      else $error("strobe captured outside a read");

endmodule : ddp_pin_interface
`default_nettype wire

// *** tb/ddp_row_model.sv ***
// Behavioural memory row model: free memory clock and read burst responder
`timescale 1ns/1ps
`default_nettype none
module ddp_row_model (
   output logic mem_clock_o,
   input wire logic [ddp_pkg::ROWS-1:0] cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   output logic [ddp_pkg::DATA_W-1:0] dq_o,
   output logic [ddp_pkg::ECC_W-1:0] cb_o,
   output logic [ddp_pkg::LANES-1:0] dqs_o
);
   // Beats of every read, check byte on top
   localparam logic [71:0] BEAT0 = 72'h5a_0123456789abcdef;
   localparam logic [71:0] BEAT1 = 72'hc3_fedcba9876543210;
   // Memory clock runs free so refresh and self refresh exit always see it
   initial begin
      mem_clock_o = 1'b0;
      forever #80 mem_clock_o = ~mem_clock_o;
   end
   // Released data shows the inverse of the last beat, so stale values never match
   initial begin
      {cb_o, dq_o} = ~BEAT1;
      dqs_o = '0;
      forever begin
         @(negedge mem_clock_o);
         // Decode mid-period while the command stands on the pins
         if (cs_n_i != 4'hf && {ras_n_i, cas_n_i, we_n_i} == 3'h5) begin
            @(posedge mem_clock_o);
            {cb_o, dq_o} = BEAT0;
            #20 dqs_o = '1;
            #20 {cb_o, dq_o} = BEAT1;
            #20 dqs_o = '0;
            // Strobes stay low as postamble, data lines released
            #20 {cb_o, dq_o} = ~BEAT1;
         end
      end
   end
endmodule : ddp_row_model
`default_nettype wire

// *** tb/ddp_pin_interface_tb.sv ***
// Self-checking bench for the DDR pin interface
`timescale 1ns/1ps
`default_nettype none
module ddp_pin_interface_tb;
   localparam int LIMIT = 10000; // Cycle ceiling, tests need about 1250
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic [2:0] cmd_op = 3'h7;
   logic [1:0] cmd_row = 2'h0;
   logic [12:0] cmd_addr = 13'h0000;
   logic [1:0] cmd_bank = 2'h0;
   logic suspend = 1'b0;
   logic wr_valid = 1'b0;
   logic [71:0] wr_data = 72'h0;
   logic cmd_ack, suspended, wr_ready, rd_valid, mck, ras_n, cas_n, we_n, gate_n;
   logic dq_oe_n, cb_oe_n, dqs_oe_n;
   logic [63:0] rd_data, dq_d, dq_p, dq_w;
   logic [7:0] rd_ecc, cb_d, cb_p, cb_w;
   logic [8:0] dqs_d, dqs_p, dqs_w;
   logic [3:0] cs_n, cke;
   logic [12:0] addr;
   logic [1:0] bank;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int acks = 0;
   int rds = 0;
   // Wire levels: the device wins only while its enable is low
   assign dq_w = dq_oe_n ? dq_p : dq_d;
   assign cb_w = cb_oe_n ? cb_p : cb_d;
   assign dqs_w = dqs_oe_n ? dqs_p : dqs_d;
   initial begin
      forever #2 clk = ~clk;
   end
   ddp_pin_interface uut (.clk_i(clk), .rst_i(rst), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op),
      .cmd_row_i(cmd_row), .cmd_addr_i(cmd_addr), .cmd_bank_i(cmd_bank), .cmd_ack_o(cmd_ack),
      .suspend_i(suspend), .suspended_o(suspended), .wr_data_valid_i(wr_valid),
      .wr_data_ready_o(wr_ready), .wr_data_i(wr_data), .rd_data_valid_o(rd_valid),
      .rd_data_o(rd_data), .rd_ecc_o(rd_ecc), .mem_clock_i(mck), .row_chip_select_n_o(cs_n),
      .mux_mem_addr_o(addr), .bank_select_o(bank), .row_strobe_n_o(ras_n),
      .col_strobe_n_o(cas_n), .mem_write_en_n_o(we_n), .row_clock_enable_o(cke),
      .mem_data_i(dq_w), .mem_data_o(dq_d), .mem_data_oe_n_o(dq_oe_n),
      .ecc_check_bits_i(cb_w), .ecc_check_bits_o(cb_d), .ecc_check_bits_oe_n_o(cb_oe_n),
      .byte_data_strobe_i(dqs_w), .byte_data_strobe_o(dqs_d),
      .byte_data_strobe_oe_n_o(dqs_oe_n), .rx_gate_feedback_out_n_o(gate_n),
      .rx_gate_feedback_in_n_i(gate_n));
   ddp_row_model rows (.mem_clock_o(mck), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n),
      .we_n_i(we_n), .dq_o(dq_p), .cb_o(cb_p), .dqs_o(dqs_p));
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   // Pulse counters and hang guard
   always @(posedge clk) begin
      cycles++;
      if (cmd_ack === 1'b1) acks++;
      if (rd_valid === 1'b1) rds++;
      if (cycles == LIMIT) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   function automatic logic [71:0] wd(input int i);
      return {8'h80 + 8'(i), {8{8'(i) + 8'h11}}};
   endfunction : wd
   // One command: hold the request until ack, check the pins in the ack cycle
   task automatic cmd(input logic [2:0] op, input logic [1:0] row, input logic [12:0] a,
         input logic [1:0] b);
      cmd_op = op;
      cmd_row = row;
      cmd_addr = a;
      cmd_bank = b;
      cmd_valid = 1'b1;
      for (int i = 0; i < 100 && cmd_ack !== 1'b1; i++) tick();
      chk("ack", 1, cmd_ack);
      chk("cs", 4'(~(4'h1 << row)), cs_n);
      chk("cmd", op, {ras_n, cas_n, we_n});
      chk("addr", a, addr);
      chk("bank", b, bank);
      tick();
      cmd_valid = 1'b0;
   endtask : cmd
   task automatic t_cmds;
      time t0;
      t0 = 0;
      for (int k = 0; k < 8; k++) begin
         if (k == 4 || k == 5) continue;
         cmd(3'(k), 2'(k), 13'h1555 ^ 13'(k), 2'(k + 1));
         if (k > 0) chk("gap", 160, $time - t0);
         t0 = $time;
         tick();
      end
      $display("test cmds done");
   endtask : t_cmds
   // Fill the buffer until it refuses, then drain it burst by burst
   task automatic t_write;
      for (int i = 0; i < 8; i++) begin
         wr_data = wd(i);
         wr_valid = 1'b1;
         for (int j = 0; j < 50 && wr_ready !== 1'b1; j++) tick();
         tick();
      end
      wr_valid = 1'b0;
      tick();
      chk("full", 0, wr_ready);
      for (int i = 0; i < 8; i += 2) begin
         cmd(3'h4, 2'(i / 2), 13'(i), 2'h0);
         for (int j = 0; j < 100 && dq_oe_n !== 1'b0; j++) tick();
         repeat (5) tick();
         chk("beat0", wd(i), {cb_w, dq_w});
         chk("dqs_hi", 10'h1ff, {dqs_oe_n, dqs_w});
         repeat (20) tick();
         chk("beat1", wd(i + 1), {cb_w, dq_w});
         chk("dqs_lo", 0, {dqs_oe_n, dqs_w});
      end
      repeat (40) tick();
      chk("drained", 3'h7, {wr_ready, dq_oe_n, cb_oe_n});
      chk("no_rd", 0, rds);
      $display("test write done");
   endtask : t_write
   task automatic t_read;
      cmd(3'h5, 2'h2, 13'h0abc, 2'h3);
      chk("gate", 0, gate_n);
      for (int i = 0; i < 300 && rd_valid !== 1'b1; i++) tick();
      chk("rd0", {1'b1, 72'h5a_0123456789abcdef}, {rd_valid, rd_ecc, rd_data});
      tick();
      for (int i = 0; i < 100 && rd_valid !== 1'b1; i++) tick();
      chk("rd1", {1'b1, 72'hc3_fedcba9876543210}, {rd_valid, rd_ecc, rd_data});
      repeat (200) tick();
      chk("gate_off", 1, gate_n);
      chk("rd_cnt", 2, rds);
      $display("test read done");
   endtask : t_read
   // Suspend refuses commands; the held request goes out after exit
   task automatic t_susp;
      int a0;
      suspend = 1'b1;
      for (int i = 0; i < 100 && cs_n !== 4'h0; i++) tick();
      chk("sr_cmd", {4'h0, 3'h1}, {cs_n, ras_n, cas_n, we_n});
      repeat (2) tick();
      chk("sr_cke", {1'b1, 4'h0}, {suspended, cke});
      a0 = acks;
      cmd_op = 3'h3;
      cmd_valid = 1'b1;
      repeat (120) tick();
      chk("refused", a0, acks);
      suspend = 1'b0;
      for (int i = 0; i < 100 && suspended !== 1'b0; i++) tick();
      chk("awake", 4'hf, cke);
      for (int i = 0; i < 100 && cmd_ack !== 1'b1; i++) tick();
      chk("late_ack", 1, cmd_ack);
      tick();
      cmd_valid = 1'b0;
      $display("test suspend done");
   endtask : t_susp
   initial begin
      repeat (10) tick();
      chk("rst", 16'hfffe, {cs_n, cke, ras_n, cas_n, we_n, dq_oe_n, cb_oe_n, dqs_oe_n,
         gate_n, wr_ready});
      rst = 1'b0;
      tick();
      tick();
      chk("ready", 1, wr_ready);
      t_cmds();
      t_write();
      t_read();
      t_susp();
      print_verdict();
   end
endmodule : ddp_pin_interface_tb
`default_nettype wire
